// ---- rtl/pnsc_top.sv ----
// PN spreading code unit: APB registers, transmit spreader, I/Q
// correlators, acquisition and aligned despreading.
// Assumes one 100 MHz clock, an APB master, and a BPSK modulator and
// sample source running on that same clock.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module pnsc_top (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire pnsc_pkg::pnsc_apb_req_s i_apb,
   output pnsc_pkg::pnsc_apb_rsp_s o_apb,
   input wire logic i_tx_data,
   output logic o_tx_take,
   output pnsc_pkg::pnsc_chip_s o_tx_chip,
   input wire pnsc_pkg::pnsc_iq_s i_rx,
   output pnsc_pkg::pnsc_rxbit_s o_rx_bit,
   output logic o_acquired
);
   ////////////////////////////////////////////////////////////////////
   // Reset release through two flops; assertion is still immediate
   logic [1:0] rst_sync_ff;
   wire rst_n = rst_sync_ff[1];

   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Register storage
   logic [7:0] len_cfg_ff, tx_hi_ff, tx_lo_ff, rx_hi_ff, rx_lo_ff;
   logic [7:0] rx_len_ff, ctrl_ff;
   logic [15:0] thresh_ff;
   logic acq_ff;
   logic [13:0] energy_ff;
   logic tx_run;

   // APB phase decode
   wire setup = i_apb.psel && !i_apb.penable;
   wire access = i_apb.psel && i_apb.penable && o_apb.pready;
   wire wr = access && i_apb.pwrite;
   wire [7:0] wbyte = i_apb.pwdata[7:0];

   // Address decode
   wire hit_len = i_apb.paddr == pnsc_pkg::OFF_LEN_CFG;
   wire hit_txh = i_apb.paddr == pnsc_pkg::OFF_TX_HI;
   wire hit_txl = i_apb.paddr == pnsc_pkg::OFF_TX_LO;
   wire hit_rxh = i_apb.paddr == pnsc_pkg::OFF_RX_HI;
   wire hit_rxl = i_apb.paddr == pnsc_pkg::OFF_RX_LO;
   wire hit_rxn = i_apb.paddr == pnsc_pkg::OFF_RX_LEN;
   wire hit_ctl = i_apb.paddr == pnsc_pkg::OFF_CTRL;
   wire hit_sts = i_apb.paddr == pnsc_pkg::OFF_STATUS;
   wire hit_thr = i_apb.paddr == pnsc_pkg::OFF_THRESH;
   wire mapped = hit_len | hit_txh | hit_txl | hit_rxh | hit_rxl |
                 hit_rxn | hit_ctl | hit_sts | hit_thr;

   // Status word: acquisition, transmitter activity, last energy
   wire [31:0] status = {2'b00, energy_ff, 14'h0000, tx_run, acq_ff};

   // Read data selection; narrow registers sit in the low bits
   wire [31:0] rd_data =
      hit_len ? {24'h000000, len_cfg_ff} :
      hit_txh ? {24'h000000, tx_hi_ff} :
      hit_txl ? {24'h000000, tx_lo_ff} :
      hit_rxh ? {24'h000000, rx_hi_ff} :
      hit_rxl ? {24'h000000, rx_lo_ff} :
      hit_rxn ? {24'h000000, rx_len_ff} :
      hit_ctl ? {24'h000000, ctrl_ff} :
      hit_sts ? status :
      hit_thr ? {16'h0000, thresh_ff} : 32'h00000000;

   ////////////////////////////////////////////////////////////////////
   // APB answer: ready is raised for the cycle after setup, so every
   // transfer finishes in its first access cycle
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         o_apb <= '0;
      end else begin
         o_apb.pready <= setup;
         o_apb.pslverr <= setup && !mapped;
         if (setup && !i_apb.pwrite) begin
            o_apb.prdata <= mapped ? rd_data : 32'h00000000;
         end
      end
   end

   // Code and length registers; each direction keeps its own pair
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         len_cfg_ff <= pnsc_pkg::RST_LEN_CFG;
         tx_hi_ff <= pnsc_pkg::RST_CODE_HI;
         tx_lo_ff <= pnsc_pkg::RST_CODE_LO;
         rx_hi_ff <= pnsc_pkg::RST_CODE_HI;
         rx_lo_ff <= pnsc_pkg::RST_CODE_LO;
         rx_len_ff <= pnsc_pkg::RST_LEN_CFG;
      end else if (wr) begin
         if (hit_len) len_cfg_ff <= wbyte;
         if (hit_txh) tx_hi_ff <= wbyte;
         if (hit_txl) tx_lo_ff <= wbyte;
         if (hit_rxh) rx_hi_ff <= wbyte;
         if (hit_rxl) rx_lo_ff <= wbyte;
         if (hit_rxn) rx_len_ff <= wbyte;
      end
   end

   // Control and threshold; the clear bit is a pulse, never stored
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_ff <= pnsc_pkg::RST_CTRL;
         thresh_ff <= pnsc_pkg::RST_THRESH;
      end else if (wr) begin
         if (hit_ctl) ctrl_ff <= {wbyte[7:3], 1'b0, wbyte[1:0]};
         if (hit_thr) thresh_ff <= i_apb.pwdata[15:0];
      end
   end

   wire acq_clr = wr && hit_ctl && wbyte[pnsc_pkg::CTRL_ACQ_CLR];
   wire tx_en = ctrl_ff[pnsc_pkg::CTRL_TX_EN];
   wire rx_en = ctrl_ff[pnsc_pkg::CTRL_RX_EN];

   // Code words and decoded lengths for both directions
   wire pnsc_pkg::pnsc_code_t tx_code = {tx_hi_ff, tx_lo_ff};
   wire pnsc_pkg::pnsc_code_t rx_code = {rx_hi_ff, rx_lo_ff};
   wire pnsc_pkg::pnsc_len_t tx_len = pnsc_pkg::pnsc_len_decode(len_cfg_ff);
   wire pnsc_pkg::pnsc_len_t rx_len = pnsc_pkg::pnsc_len_decode(rx_len_ff);

   ////////////////////////////////////////////////////////////////////
   // Transmit chain: any loaded pattern, m-sequence, Barker or Willard
   // code goes out unchanged, one chip per clock
   pnsc_spreader u_spreader (
      .i_clock(i_clock),
      .i_rst_n(rst_n),
      .i_enable(tx_en),
      .i_code(tx_code),
      .i_len(tx_len),
      .i_data(i_tx_data),
      .o_take(o_tx_take),
      .o_run(tx_run),
      .o_chip(o_tx_chip)
   );

   ////////////////////////////////////////////////////////////////////
   // Receive: one matched filter per channel
   logic ci_valid, cq_valid;
   pnsc_pkg::pnsc_corr_t corr_i, corr_q;

   pnsc_correlator u_corr_i (
      .i_clock(i_clock),
      .i_rst_n(rst_n),
      .i_valid(i_rx.valid),
      .i_smp(i_rx.i),
      .i_code(rx_code),
      .i_len(rx_len),
      .o_valid(ci_valid),
      .o_corr(corr_i)
   );

   pnsc_correlator u_corr_q (
      .i_clock(i_clock),
      .i_rst_n(rst_n),
      .i_valid(i_rx.valid),
      .i_smp(i_rx.q),
      .i_code(rx_code),
      .i_len(rx_len),
      .o_valid(cq_valid),
      .o_corr(corr_q)
   );

   // Magnitude of a correlation result
   function automatic logic [12:0] mag(input pnsc_pkg::pnsc_corr_t c);
      return c[12] ? 13'(-c) : 13'(c);
   endfunction

   // Noncoherent energy; carrier phase is unknown before acquisition
   wire [13:0] energy = {1'b0, mag(corr_i)} + {1'b0, mag(corr_q)};
   wire detect = ci_valid && rx_en && !acq_ff && ({2'b00, energy} >= thresh_ff);

   ////////////////////////////////////////////////////////////////////
   // Sample pipeline: holds the sample whose correlation is now visible
   pnsc_pkg::pnsc_iq_s rxd_ff;

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         rxd_ff <= '0;
      end else begin
         rxd_ff <= i_rx;
      end
   end

   // Last correlation energy kept for software, taken on every valid result
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         energy_ff <= 14'h0000;
      end else if (ci_valid) begin
         energy_ff <= energy;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Acquisition flag; a detection in the clear cycle still wins
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         acq_ff <= 1'b0;
      end else if (detect) begin
         acq_ff <= 1'b1;
      end else if (acq_clr || !rx_en) begin
         acq_ff <= 1'b0;
      end
   end

   // Local code generator and integrator, started at the peak
   pnsc_pkg::pnsc_code_t lcode_ff;
   pnsc_pkg::pnsc_len_t rcnt_ff;
   pnsc_pkg::pnsc_corr_t acc_ff;
   wire rx_step = acq_ff && rxd_ff.valid;
   wire rx_last = rcnt_ff == rx_len - 5'd1;
   wire pnsc_pkg::pnsc_corr_t acc_nxt = acc_ff + pnsc_pkg::pnsc_term(lcode_ff[15], rxd_ff.i);

   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         lcode_ff <= 16'h0000;
         rcnt_ff <= 5'h00;
         acc_ff <= '0;
      end else if (detect || (rx_step && rx_last)) begin
         lcode_ff <= pnsc_pkg::pnsc_align(rx_code, rx_len);
         rcnt_ff <= 5'h00;
         acc_ff <= '0;
      end else if (rx_step) begin
         lcode_ff <= lcode_ff << 1;
         rcnt_ff <= rcnt_ff + 5'd1;
         acc_ff <= acc_nxt;
      end
   end

   // Decided bit: positive sum means the data bit was zero
   always_ff @(posedge i_clock or negedge rst_n) begin
      if (!rst_n) begin
         o_rx_bit <= '0;
         o_acquired <= 1'b0;
      end else begin
         o_rx_bit.valid <= rx_step && rx_last;
         o_rx_bit.data <= (rx_step && rx_last) ? acc_nxt[12] : o_rx_bit.data;
         o_acquired <= acq_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!rst_n);

   property p_apb_ready;
      setup |=> o_apb.pready ##1 !o_apb.pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("no one-cycle ready");

   property p_unmapped;
      setup && !mapped |=> o_apb.pslverr && o_apb.pready;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped without error");

   property p_tx_write;
      wr && hit_txh |=> tx_hi_ff == $past(i_apb.pwdata[7:0]) && $stable(rx_hi_ff);
   endproperty
   a_tx_write: assert property (p_tx_write) else $error("tx code write lost");

   property p_rx_sep;
      wr && (hit_rxh || hit_rxl) |=> $stable(tx_code);
   endproperty
   a_rx_sep: assert property (p_rx_sep) else $error("rx write disturbed tx");

   property p_len_map;
      len_cfg_ff[6:5] == 2'b01 |-> tx_len == 5'd13 && rx_len != 5'd0;
   endproperty
   a_len_map: assert property (p_len_map) else $error("length decode wrong");

   property p_acq;
      detect |=> acq_ff && rcnt_ff == 5'h00 ##1 o_acquired;
   endproperty
   a_acq: assert property (p_acq) else $error("acquisition not declared");

   property p_despread;
      rx_step && rx_last |=> o_rx_bit.valid && rcnt_ff == 5'h00;
   endproperty
   a_despread: assert property (p_despread) else $error("no bit at symbol end");

   property p_iq;
      ci_valid == cq_valid;
   endproperty
   a_iq: assert property (p_iq) else $error("I and Q out of step");

   // Status, lock clearing, register separation, local code, read data hold and unmapped write checks
   property p_status;
      setup && hit_sts && !i_apb.pwrite |=> o_apb.prdata[1:0] == $past({tx_run, acq_ff});
   endproperty
   a_status: assert property (p_status) else $error("status bits wrong");

   property p_clr;
      acq_ff && acq_clr && !detect |=> !acq_ff;
   endproperty
   a_clr: assert property (p_clr) else $error("clear ignored");

   property p_rx_off;
      !rx_en |=> !acq_ff;
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("acquired while rx off");

   property p_rx_len;
      wr && hit_rxn |=> rx_len_ff == $past(wbyte) && $stable(len_cfg_ff);
   endproperty
   a_rx_len: assert property (p_rx_len) else $error("rx length write lost");

   property p_tx_len;
      wr && hit_len |=> $stable(rx_len_ff);
   endproperty
   a_tx_len: assert property (p_tx_len) else $error("tx length disturbed rx");

   property p_align;
      detect |=> lcode_ff[15] == $past(rx_code[4'(rx_len - 5'd1)]);
   endproperty
   a_align: assert property (p_align) else $error("local code not aligned");

   property p_rx_shift;
      rx_step && !rx_last |=> lcode_ff == {$past(lcode_ff[14:0]), 1'b0};
   endproperty
   a_rx_shift: assert property (p_rx_shift) else $error("local code not shifted");

   property p_rd_hold;
      !(setup && !i_apb.pwrite) |=> $stable(o_apb.prdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data not held");

   property p_bad_wr;
      wr && !mapped |=> $stable(tx_code) && $stable(rx_code) && $stable(thresh_ff);
   endproperty
   a_bad_wr: assert property (p_bad_wr) else $error("unmapped write landed");

   c_acq: cover property (detect ##[1:40] o_rx_bit.valid);
   c_take: cover property (o_tx_take ##[1:20] o_tx_take);
   c_err: cover property (o_apb.pslverr);
   c_clr: cover property (acq_ff ##1 acq_clr ##1 !acq_ff);
   c_status: cover property (setup && hit_sts);
endmodule

// ---- shared/pnsc_pkg.sv ----
// Constants, types and helpers for the PN spreading code unit.
// Assumes one 100 MHz clock and an APB master with 32-bit data.
////////////////////////////////////////////////////////////////////////
package pnsc_pkg;
   // Register byte addresses
   localparam logic [7:0] OFF_LEN_CFG = 8'h00;
   localparam logic [7:0] OFF_TX_HI = 8'h04;
   localparam logic [7:0] OFF_TX_LO = 8'h08;
   localparam logic [7:0] OFF_RX_HI = 8'h0c;
   localparam logic [7:0] OFF_RX_LO = 8'h10;
   localparam logic [7:0] OFF_RX_LEN = 8'h14;
   localparam logic [7:0] OFF_CTRL = 8'h18;
   localparam logic [7:0] OFF_STATUS = 8'h1c;
   localparam logic [7:0] OFF_THRESH = 8'h20;
   // Field positions
   localparam int LEN_SEL_LSB = 5;
   localparam int LEN_SEL_MSB = 6;
   localparam int LEN_CUST_MSB = 3;
   localparam int CTRL_TX_EN = 0;
   localparam int CTRL_RX_EN = 1;
   localparam int CTRL_ACQ_CLR = 2;
   localparam int STAT_ACQ = 0;
   localparam int STAT_TX_RUN = 1;
   localparam int STAT_EN_LSB = 16;
   // Reset values: eleven-chip Barker code, length select 00
   localparam logic [7:0] RST_LEN_CFG = 8'h00;
   localparam logic [7:0] RST_CODE_HI = 8'h07;
   localparam logic [7:0] RST_CODE_LO = 8'h12;
   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [15:0] RST_THRESH = 16'h0100;

   typedef logic [15:0] pnsc_code_t;
   typedef logic [4:0] pnsc_len_t;
   typedef logic signed [7:0] pnsc_smp_t;
   typedef logic signed [12:0] pnsc_corr_t;

   localparam pnsc_len_t LEN_MAX = 5'd16;
   localparam pnsc_len_t LEN_11 = 5'd11;
   localparam pnsc_len_t LEN_13 = 5'd13;

   typedef enum logic [1:0] {
      LSEL_11 = 2'b00,
      LSEL_13 = 2'b01,
      LSEL_16 = 2'b10,
      LSEL_CUSTOM = 2'b11
   } pnsc_len_sel_e;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [7:0] paddr;
      logic [31:0] pwdata;
   } pnsc_apb_req_s;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } pnsc_apb_rsp_s;

   typedef struct packed {
      logic valid;
      logic first;
      logic code_chip;
      logic spread;
   } pnsc_chip_s;

   typedef struct packed {
      logic valid;
      pnsc_smp_t i;
      pnsc_smp_t q;
   } pnsc_iq_s;

   typedef struct packed {
      logic valid;
      logic data;
   } pnsc_rxbit_s;

   // Length field decode; custom length is bits 3:0 plus one
   function automatic pnsc_len_t pnsc_len_decode(input logic [7:0] cfg);
      unique case (pnsc_len_sel_e'(cfg[LEN_SEL_MSB:LEN_SEL_LSB]))
         LSEL_11: return LEN_11;
         LSEL_13: return LEN_13;
         LSEL_16: return LEN_MAX;
         LSEL_CUSTOM: return 5'(cfg[LEN_CUST_MSB:0]) + 5'd1;
      endcase
   endfunction

   // Moves the low len bits to the top so the first chip is bit 15
   function automatic pnsc_code_t pnsc_align(input pnsc_code_t code,
                                             input pnsc_len_t len);
      return code << (LEN_MAX - len);
   endfunction

   // Sample weighted by a code chip: one keeps sign, zero negates
   function automatic pnsc_corr_t pnsc_term(input logic c, input pnsc_smp_t s);
      pnsc_corr_t w;
      w = 13'(s);
      return c ? w : -w;
   endfunction
endpackage

// ---- rtl/pnsc_spreader.sv ----
// Transmit chip generator: loads the code, shifts it out, XORs data.
// Assumes a synchronous reset copy and same-clock data input.
`timescale 1ns/1ps
module pnsc_spreader (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_enable,
   input wire pnsc_pkg::pnsc_code_t i_code,
   input wire pnsc_pkg::pnsc_len_t i_len,
   input wire logic i_data,
   output logic o_take,
   output logic o_run,
   output pnsc_pkg::pnsc_chip_s o_chip
);
   pnsc_pkg::pnsc_code_t shift_ff, code_ff;
   pnsc_pkg::pnsc_len_t cnt_ff, len_ff;
   logic run_ff, data_ff;
   wire last = run_ff && (cnt_ff == len_ff - 5'd1);
   wire load = i_enable && (!run_ff || last);

   ////////////////////////////////////////////////////////////////////
   // Shift register; a new symbol only starts on a boundary
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         shift_ff <= 16'h0000;
         code_ff <= 16'h0000;
         cnt_ff <= 5'h00;
         len_ff <= 5'h10;
         run_ff <= 1'b0;
         data_ff <= 1'b0;
      end else if (load) begin
         shift_ff <= pnsc_pkg::pnsc_align(i_code, i_len);
         code_ff <= i_code;
         cnt_ff <= 5'h00;
         len_ff <= i_len;
         run_ff <= 1'b1;
         data_ff <= i_data;
      end else if (run_ff) begin
         shift_ff <= shift_ff << 1;
         cnt_ff <= cnt_ff + 5'd1;
         run_ff <= !last;
      end
   end

   // Registered chip output, one chip per clock
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_chip <= '0;
         o_take <= 1'b0;
         o_run <= 1'b0;
      end else begin
         o_chip.valid <= run_ff;
         o_chip.first <= run_ff && (cnt_ff == 5'h00);
         o_chip.code_chip <= shift_ff[15];
         o_chip.spread <= shift_ff[15] ^ data_ff;
         o_take <= load;
         o_run <= run_ff;
      end
   end

   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_rst_n);

   property p_xor;
      run_ff |=> o_chip.spread == ($past(data_ff) ^ $past(shift_ff[15]));
   endproperty
   a_xor: assert property (p_xor) else $error("spread chip is not data xor code");

   property p_pattern;
      run_ff |-> shift_ff[15] == code_ff[4'(len_ff - 5'd1 - cnt_ff)];
   endproperty
   a_pattern: assert property (p_pattern) else $error("chip order wrong");

   property p_reload;
      last && i_enable |=> run_ff && cnt_ff == 5'h00 && len_ff == $past(i_len);
   endproperty
   a_reload: assert property (p_reload) else $error("code not reloaded");
endmodule

// ---- rtl/pnsc_correlator.sv ----
// Parallel matched filter for one real channel over up to 16 chips.
// Assumes samples arrive on the same clock with a valid qualifier.
`timescale 1ns/1ps
module pnsc_correlator (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire logic i_valid,
   input wire pnsc_pkg::pnsc_smp_t i_smp,
   input wire pnsc_pkg::pnsc_code_t i_code,
   input wire pnsc_pkg::pnsc_len_t i_len,
   output logic o_valid,
   output pnsc_pkg::pnsc_corr_t o_corr
);
   pnsc_pkg::pnsc_smp_t line_ff [15];
   pnsc_pkg::pnsc_corr_t sum;

   ////////////////////////////////////////////////////////////////////
   // Tap 0 is the newest sample and meets the last chip (code bit 0)
   always_comb begin
      sum = '0;
      for (int k = 0; k < 16; k++) begin
         if (5'(k) < i_len) begin
            sum = sum + pnsc_pkg::pnsc_term(i_code[k], (k == 0) ? i_smp : line_ff[k-1]);
         end
      end
   end

   // Delay line and registered result
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int k = 0; k < 15; k++) begin
            line_ff[k] <= 8'h00;
         end
         o_valid <= 1'b0;
         o_corr <= '0;
      end else begin
         o_valid <= i_valid;
         if (i_valid) begin
            line_ff[0] <= i_smp;
            for (int k = 1; k < 15; k++) begin
               line_ff[k] <= line_ff[k-1];
            end
            o_corr <= sum;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   property p_lat;
      @(posedge i_clock) disable iff (!i_rst_n)
      i_valid |=> o_valid ##1 (o_valid == $past(i_valid));
   endproperty
   a_lat: assert property (p_lat) else $error("correlation late");
endmodule

// ---- testbench/pnsc_bpsk_loop.sv ----
// Far-side model: the BPSK modulator looped back as chip-rate I/Q samples.
// Assumes the unit's clock and reset; each sample trails its chip by one cycle.
`timescale 1ns/1ps
module pnsc_bpsk_loop (
   input wire logic i_clock,
   input wire logic i_rst_n,
   input wire pnsc_pkg::pnsc_chip_s i_chip,
   output pnsc_pkg::pnsc_iq_s o_rx
);
   ////////////////////////////////////////////////////////////////////////
   // Spread one gives a positive sample; idle lines toggle so stale data never looks valid
   always_ff @(posedge i_clock or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rx <= '0;
      end else if (i_chip.valid) begin
         o_rx.valid <= 1'b1;
         o_rx.i <= i_chip.spread ? 8'sh40 : -8'sh40;
         o_rx.q <= 8'sh00;
      end else begin
         o_rx.valid <= 1'b0;
         o_rx.i <= ~o_rx.i;
         o_rx.q <= ~o_rx.q;
      end
   end
endmodule

// ---- testbench/pnsc_top_tb_top.sv ----
// Self-checking bench: APB registers, chip stream per code, loopback acquisition.
// Assumes the far-side model turns chips straight back into I/Q samples.
`timescale 1ns/1ps
module pnsc_top_tb_top;
   logic i_clock = 1'b0;
   logic i_rst_n = 1'b0;
   pnsc_pkg::pnsc_apb_req_s apb_req = '0;
   pnsc_pkg::pnsc_apb_rsp_s o_apb;
   pnsc_pkg::pnsc_chip_s o_tx_chip;
   pnsc_pkg::pnsc_iq_s rx_smp;
   pnsc_pkg::pnsc_rxbit_s o_rx_bit;
   pnsc_pkg::pnsc_code_t cur_code = 16'h0712;
   logic i_tx_data = 1'b0;
   logic o_tx_take, o_acquired, dbit, ecode, nbit, err;
   logic was_valid = 1'b0;
   logic was_acq = 1'b0;
   logic txq[$] = '{1'b0};
   logic rxq[$] = '{1'b0};
   logic [31:0] rd;
   logic [7:0] w [6];
   int num_errors = 0;
   int cmp_count = 0;
   int cur_len = 11;
   int idx = 0;
   int rx_n = 0;
   // Loopback code first, while the correlator window still holds reset zeros
   logic [15:0] t_code [12] = '{16'h0712, 16'h0017, 16'h09af, 16'h0006, 16'h000e, 16'h001d,
      16'h0072, 16'h1f35, 16'h0768, 16'h1f28, 16'h000d, 16'h0000};
   logic [7:0] t_cfg [12] = '{8'h00, 8'h66, 8'h6e, 8'h62, 8'h63, 8'h64, 8'h66, 8'h20, 8'h00,
      8'h20, 8'h66, 8'h40};
   int t_len [12] = '{11, 7, 15, 3, 4, 5, 7, 13, 11, 13, 7, 16};
   logic [7:0] r_addr [8] = '{pnsc_pkg::OFF_LEN_CFG, pnsc_pkg::OFF_TX_HI, pnsc_pkg::OFF_TX_LO,
      pnsc_pkg::OFF_RX_HI, pnsc_pkg::OFF_RX_LO, pnsc_pkg::OFF_RX_LEN, pnsc_pkg::OFF_CTRL,
      pnsc_pkg::OFF_THRESH};
   logic [31:0] r_val [8] = '{32'h0, 32'h07, 32'h12, 32'h07, 32'h12, 32'h0, 32'h0, 32'h100};

   pnsc_top dut_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_apb(apb_req), .o_apb(o_apb),
      .i_tx_data(i_tx_data), .o_tx_take(o_tx_take), .o_tx_chip(o_tx_chip), .i_rx(rx_smp),
      .o_rx_bit(o_rx_bit), .o_acquired(o_acquired));
   pnsc_bpsk_loop far_u (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_chip(o_tx_chip),
      .o_rx(rx_smp));

   always #5 i_clock = ~i_clock;

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits for pready, so a stalled slave ends on the bound
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge i_clock);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge i_clock);
      apb_req.penable <= 1'b1;
      // Ready, read data and error are taken at the edge that ends the access
      do begin
         @(posedge i_clock);
         n++;
      end while (o_apb.pready !== 1'b1 && n < 50);
      if (n >= 50) num_errors++;
      rd = o_apb.prdata;
      err = o_apb.pslverr;
      apb_req <= '0;
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic experr);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
      chk({31'h0, err}, {31'h0, experr});
   endtask

   task automatic wait_idle;
      for (int n = 0; n < 40 && o_tx_chip.valid !== 1'b0; n++) @(negedge i_clock);
      @(negedge i_clock);
      chk({31'h0, o_tx_chip.valid}, 32'h0);
   endtask

   task automatic finish_test;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // Fresh random data bit after each take, noted for both directions
   always @(negedge i_clock) begin
      if (o_tx_take === 1'b1) begin
         @(posedge i_clock);
         nbit = 1'($urandom);
         i_tx_data <= nbit;
         txq.push_back(nbit);
         rxq.push_back(nbit);
      end
   end

   // Output watcher: chip order, symbol length, then despread bits after lock
   always @(negedge i_clock) begin
      if (was_valid && (o_tx_chip.valid !== 1'b1 || o_tx_chip.first === 1'b1)) begin
         chk(32'(idx), 32'(cur_len));
      end
      if (o_tx_chip.first === 1'b1) begin
         idx = 0;
         dbit = (txq.size() > 0) ? txq.pop_front() : 1'bx;
      end
      if (o_tx_chip.valid === 1'b1) begin
         ecode = cur_code[cur_len - 1 - idx];
         chk({o_tx_chip.code_chip, o_tx_chip.spread}, {ecode, ecode ^ dbit});
         idx++;
      end
      was_valid = o_tx_chip.valid === 1'b1;
      // Symbol that produced the lock is not decoded
      if (o_acquired === 1'b1 && !was_acq && rxq.size() > 0) void'(rxq.pop_front());
      was_acq = o_acquired === 1'b1;
      if (o_rx_bit.valid === 1'b1) begin
         rx_n++;
         chk(o_rx_bit.data, (rxq.size() > 0) ? rxq.pop_front() : 1'bx);
      end
   end

   initial begin
      #100000;
      num_errors++;
      finish_test();
   end

   initial begin
      void'($urandom(96976));
      repeat (3) @(posedge i_clock);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clock);
      for (int k = 0; k < 8; k++) rdchk(r_addr[k], r_val[k], 1'b0);
      rdchk(8'h24, 32'h0, 1'b1);
      for (int k = 1; k < 6; k++) begin
         w[k] = 8'($urandom);
         apb(1'b1, r_addr[k], {24'h0, w[k]});
      end
      for (int k = 1; k < 6; k++) rdchk(r_addr[k], {24'h0, w[k]}, 1'b0);
      apb(1'b1, 8'h24, 32'hff);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, pnsc_pkg::OFF_RX_LEN, 32'h0);
      apb(1'b1, pnsc_pkg::OFF_RX_HI, 32'h07);
      apb(1'b1, pnsc_pkg::OFF_RX_LO, 32'h12);
      // Every code but the last, a random 16-chip one, with junk above its length; the first run also feeds the receiver
      for (int e = 0; e < 12; e++) begin
         cur_len = t_len[e];
         cur_code = (e == 11) ? 16'($urandom) : t_code[e] | (16'($urandom) << cur_len);
         apb(1'b1, pnsc_pkg::OFF_TX_HI, {24'h0, cur_code[15:8]});
         apb(1'b1, pnsc_pkg::OFF_TX_LO, {24'h0, cur_code[7:0]});
         apb(1'b1, pnsc_pkg::OFF_LEN_CFG, {24'h0, t_cfg[e]});
         apb(1'b1, pnsc_pkg::OFF_CTRL, (e == 0) ? 32'h3 : 32'h1);
         repeat (cur_len * ((e == 0) ? 10 : 4)) @(posedge i_clock);
         if (e == 0) begin
            chk({31'h0, o_acquired}, 32'h1);
            apb(1'b0, pnsc_pkg::OFF_STATUS, 32'h0);
            chk(rd & 32'h3, 32'h3);
            // Stop sending with the receiver still on, then clear the lock by hand
            apb(1'b1, pnsc_pkg::OFF_CTRL, 32'h2);
            wait_idle();
            apb(1'b1, pnsc_pkg::OFF_CTRL, 32'h6);
            repeat (2) @(negedge i_clock);
            chk({31'h0, o_acquired}, 32'h0);
         end
         apb(1'b1, pnsc_pkg::OFF_CTRL, 32'h0);
         wait_idle();
         if (e == 0) chk({31'h0, o_acquired}, 32'h0);
         if (e == 0) chk(32'(rx_n >= 6), 32'h1);
      end
      finish_test();
   end
endmodule
